// file: rtl/stepper_push_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef STEPPER_PUSH_MAP_VH
`define STEPPER_PUSH_MAP_VH
// Register byte offsets
`define OFS_SYS_CFG 12'h000
`define OFS_APP_CFG 12'h004
`define OFS_INPOS_BAND 12'h008
`define OFS_INPOS_OFFSET 12'h00c
`define OFS_RET_SPEED 12'h010
`define OFS_RET_ACCEL 12'h014
`define OFS_RET_START 12'h018
`define OFS_DEV_LIMIT 12'h01c
`define OFS_STATUS 12'h020
`define OFS_CMD_POS 12'h024
`define OFS_HOME_POS 12'h028
`define OFS_ACT_POS 12'h02c
`define OFS_TORQUE 12'h030
`define OFS_WARN_CLR 12'h034
`define OFS_JOG_CTRL 12'h038
`define OFS_JOG_SPEED 12'h03c
`define OFS_JOG_ACCEL 12'h040
`define OFS_JOG_START 12'h044
`define OFS_PUSH_CUR0 12'h080
// System config fields (bit 0 direction: 0 plus-is-cw, 1 plus-is-ccw)
`define SYS_DIR_BIT 0
// App config fields
`define APP_PUSH_SEL_BIT 0
`define APP_WARN_EN_BIT 1
// Status fields
`define ST_IN_POS_BIT 0
`define ST_TLIM_BIT 1
`define ST_PUSH_BIT 2
`define ST_RET_BIT 3
`define ST_WARN_BIT 4
`define ST_ALARM_BIT 5
`define ST_DIR_BIT 6
`define ST_JOG_BIT 7
// Reset values
`define RST_SYS_CFG 32'h0000_0000
`define RST_APP_CFG 32'h0000_0000
`define RST_INPOS_BAND 16'h000a
`define RST_INPOS_OFFSET 16'h0000
`define RST_RET_SPEED 16'h0010
`define RST_RET_ACCEL 16'h0001
`define RST_RET_START 16'h0100
`define RST_DEV_LIMIT 16'h2000
`define RST_JOG_SPEED 16'h0010
`define RST_JOG_ACCEL 16'h0001
`define RST_JOG_START 16'h0100
// Push current defaults: 30.0 % in tenths, step of 10.0 %
`define PUSH_CUR_BASE 10'h12c
`define PUSH_CUR_STEP 10'h064
`define PUSH_CUR_FULL 10'h3e8
// Fast catch-up reload count, one step every 5 clocks after a load is removed
`define FAST_PERIOD 16'h0004
`endif

// file: rtl/stepper_push_home.v
// Command-side position, push-motion and home-return logic of a stepper
//
// Notes on behaviour
// (RULE1) Plus-is-cw: forward counts up, turns cw
// (RULE2) Plus-is-ccw: forward counts up, turns ccw
// (RULE3) Direction setting latched only at power-up
// (RULE4) In-position band compared after offset correction
// (RULE5) Push needs mode, push input, then pulses
// (RULE6) Push keeps accumulating pulses when stalled
// (RULE7) Three select bits index eight currents
// (RULE8) Torque limited to selected push current
// (RULE9) Torque-limit flag when limit is reached
// (RULE10) Push holds while push input stays high
// (RULE11) No standstill cutback during push
// (RULE12) Unloaded push runs accumulated pulses fast
// (RULE13) Deviation alarm on prolonged push
// (RULE14) Jog only from operator tool button
// (RULE15) Home-return request starts return move
// (RULE16) Home is power-up or position-reset position
// (RULE17) Return uses speed, accel, start speed
// (RULE18) Step pulses ignored during home return
// (RULE19) Resolution select with warning blocks return
// (RULE20) Position reset during return stops there
// (RULE21) Forward line counts up, reverse down
// (RULE22) Command position is signed up/down counter
// (RULE23) Control inputs pass two-stage synchroniser
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "stepper_push_map.vh"
module stepper_push_home (
  input wire clk, // 25 MHz clock
  input wire rst, // Synchronous reset, active high
  input wire power_up, // Power cycle event, loads system parameters
  input wire pulse_fwd, // Forward step pulse line
  input wire pulse_rev, // Reverse step pulse line
  input wire push_mode_in, // Push-motion request
  input wire current_select_bit0, // Push current select, lsb
  input wire current_select_bit1, // Push current select
  input wire current_select_bit2, // Push current select, msb
  input wire home_return_in, // Home-return request
  input wire position_reset_in, // Position reset / home capture
  input wire resolution_select_in, // Resolution select input
  input wire load_held, // Shaft stalled against a load
  input wire [9:0] torque_meas, // Measured torque, tenths of percent
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg step_out, // One step to the drive stage
  output reg step_cw, // Shaft direction of that step, 1 is cw
  output reg [9:0] torque_limit, // Current limit, tenths of percent
  output reg torque_limit_flag, // Torque reached push current
  output reg in_position, // Stopped within band
  output reg standstill_cutback, // Standstill current reduction allowed
  output reg deviation_alarm, // Excessive position deviation
  output reg bad_data_warning // Return blocked warning
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam NSYNC = 9;
  wire [NSYNC-1:0] raw_in = {resolution_select_in, position_reset_in,
    home_return_in, current_select_bit2, current_select_bit1,
    current_select_bit0, push_mode_in, pulse_rev, pulse_fwd};
  reg [NSYNC-1:0] sync1;
  reg [NSYNC-1:0] sync2;
  reg [NSYNC-1:0] sync3;
  // (RULE23) Two-flop synchronisers
  always @(posedge clk) begin
    if (rst) begin
      sync1 <= {NSYNC{1'b0}};
      sync2 <= {NSYNC{1'b0}};
      sync3 <= {NSYNC{1'b0}};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire fwd_edge = sync2[0] & ~sync3[0];
  wire rev_edge = sync2[1] & ~sync3[1];
  wire push_in = sync2[2];
  wire [2:0] cur_idx = sync2[5:3];
  wire ret_edge = sync2[6] & ~sync3[6];
  wire preset = sync2[7];
  wire res_sel = sync2[8];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] sys_cfg;
  reg dir_ccw;
  reg [31:0] app_cfg;
  reg [15:0] inpos_band;
  reg signed [15:0] inpos_offset;
  reg [15:0] ret_speed;
  reg [15:0] ret_accel;
  reg [15:0] ret_start;
  reg [15:0] dev_limit;
  reg [15:0] jog_speed;
  reg [15:0] jog_accel;
  reg [15:0] jog_start;
  reg jog_button;
  reg jog_dir;
  reg [9:0] push_cur [0:7];
  reg signed [31:0] cmd_pos;
  reg signed [31:0] act_pos;
  reg signed [31:0] home_pos;
  reg pushing;
  reg returning;
  reg [15:0] speed;
  reg [15:0] rate_cnt;
  reg fast_run;
  reg jogging;

  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire warn_en = app_cfg[`APP_WARN_EN_BIT];
  wire push_sel = app_cfg[`APP_PUSH_SEL_BIT];
  wire signed [31:0] deviation = cmd_pos - act_pos;
  wire [31:0] abs_dev = deviation[31] ? -deviation : deviation;
  wire signed [31:0] corr_dev = deviation +
    {{16{inpos_offset[15]}}, inpos_offset};
  wire [31:0] abs_corr = corr_dev[31] ? -corr_dev : corr_dev;
  wire push_ok = push_sel & push_in;
  wire reg_hit = (paddr < `OFS_JOG_START + 12'h004) ||
    (paddr[11:5] == 7'h04);
  // Home return target relative to the present shaft position
  wire signed [31:0] to_home = home_pos - act_pos;
  // Status word, one flag per bit
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_IN_POS_BIT] = in_position;
    status_word[`ST_TLIM_BIT] = torque_limit_flag;
    status_word[`ST_PUSH_BIT] = pushing;
    status_word[`ST_RET_BIT] = returning;
    status_word[`ST_WARN_BIT] = bad_data_warning;
    status_word[`ST_ALARM_BIT] = deviation_alarm;
    status_word[`ST_DIR_BIT] = dir_ccw;
    status_word[`ST_JOG_BIT] = jogging;
  end

  // (RULE7) Default currents 30.0 to 100.0 in ten-percent steps
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cur
      // Sized copies keep reset value and address at their own widths
      localparam [9:0] CUR_RST = `PUSH_CUR_BASE + gi * `PUSH_CUR_STEP;
      localparam [11:0] CUR_ADR = `OFS_PUSH_CUR0 + gi * 4;
      always @(posedge clk) begin
        if (rst)
          push_cur[gi] <= CUR_RST;
        else if (wr && paddr == CUR_ADR)
          push_cur[gi] <= (pwdata[9:0] > `PUSH_CUR_FULL) ?
            `PUSH_CUR_FULL : pwdata[9:0];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      sys_cfg <= `RST_SYS_CFG;
      app_cfg <= `RST_APP_CFG;
      inpos_band <= `RST_INPOS_BAND;
      inpos_offset <= `RST_INPOS_OFFSET;
      ret_speed <= `RST_RET_SPEED;
      ret_accel <= `RST_RET_ACCEL;
      ret_start <= `RST_RET_START;
      dev_limit <= `RST_DEV_LIMIT;
      jog_speed <= `RST_JOG_SPEED;
      jog_accel <= `RST_JOG_ACCEL;
      jog_start <= `RST_JOG_START;
      jog_button <= 1'b0;
      jog_dir <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & ~reg_hit;
      if (wr) begin
        case (paddr)
          `OFS_SYS_CFG: sys_cfg <= pwdata;
          `OFS_APP_CFG: app_cfg <= pwdata;
          `OFS_INPOS_BAND: inpos_band <= pwdata[15:0];
          `OFS_INPOS_OFFSET: inpos_offset <= pwdata[15:0];
          `OFS_RET_SPEED: ret_speed <= pwdata[15:0];
          `OFS_RET_ACCEL: ret_accel <= pwdata[15:0];
          `OFS_RET_START: ret_start <= pwdata[15:0];
          `OFS_DEV_LIMIT: dev_limit <= pwdata[15:0];
          `OFS_JOG_SPEED: jog_speed <= pwdata[15:0];
          `OFS_JOG_ACCEL: jog_accel <= pwdata[15:0];
          `OFS_JOG_START: jog_start <= pwdata[15:0];
          // (RULE14) Tool button holds jog, no pin can
          `OFS_JOG_CTRL: begin
            jog_button <= pwdata[0];
            jog_dir <= pwdata[1];
          end
          default: ;
        endcase
      end
      if (acc && !pwrite) begin
        case (paddr)
          `OFS_SYS_CFG: prdata <= sys_cfg;
          `OFS_APP_CFG: prdata <= app_cfg;
          `OFS_INPOS_BAND: prdata <= {16'h0000, inpos_band};
          `OFS_INPOS_OFFSET: prdata <= {16'h0000, inpos_offset};
          `OFS_RET_SPEED: prdata <= {16'h0000, ret_speed};
          `OFS_RET_ACCEL: prdata <= {16'h0000, ret_accel};
          `OFS_RET_START: prdata <= {16'h0000, ret_start};
          `OFS_DEV_LIMIT: prdata <= {16'h0000, dev_limit};
          `OFS_STATUS: prdata <= status_word;
          `OFS_CMD_POS: prdata <= cmd_pos;
          `OFS_HOME_POS: prdata <= home_pos;
          `OFS_ACT_POS: prdata <= act_pos;
          `OFS_TORQUE: prdata <= {22'h000000, torque_limit};
          `OFS_JOG_CTRL: prdata <= {30'h00000000, jog_dir, jog_button};
          `OFS_JOG_SPEED: prdata <= {16'h0000, jog_speed};
          `OFS_JOG_ACCEL: prdata <= {16'h0000, jog_accel};
          `OFS_JOG_START: prdata <= {16'h0000, jog_start};
          default: prdata <= (paddr[11:5] == 7'h04) ?
            {22'h000000, push_cur[paddr[4:2]]} : 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Direction latch; home is captured in the motion block below
  // ----------------------------------------------------------------
  // (RULE3) Direction only taken at a power cycle
  always @(posedge clk) begin
    if (rst)
      dir_ccw <= 1'b0;
    else if (power_up)
      dir_ccw <= sys_cfg[`SYS_DIR_BIT];
  end

  // ----------------------------------------------------------------
  // Motion state and position counters
  // ----------------------------------------------------------------
  // Profile: period count falls by accel each step from start speed
  // toward the operating speed, a simple linear ramp.
  wire step_due = (rate_cnt == 16'h0000);
  wire ret_go = ret_edge & ~(res_sel & warn_en) & ~returning;
  always @(posedge clk) begin
    if (rst) begin
      cmd_pos <= 32'h0000_0000;
      act_pos <= 32'h0000_0000;
      home_pos <= 32'h0000_0000;
      pushing <= 1'b0;
      returning <= 1'b0;
      speed <= 16'h0000;
      rate_cnt <= 16'h0000;
      fast_run <= 1'b0;
      jogging <= 1'b0;
      step_out <= 1'b0;
      step_cw <= 1'b0;
      bad_data_warning <= 1'b0;
    end else begin
      step_out <= 1'b0;
      // (RULE5) Push only with mode, input and pulses
      if (!push_ok)
        pushing <= 1'b0;
      else if (fwd_edge | rev_edge)
        pushing <= 1'b1;
      // (RULE19) Blocked return raises the warning
      if (ret_edge && res_sel && warn_en)
        bad_data_warning <= 1'b1;
      else if (preset)
        bad_data_warning <= 1'b0;
      // (RULE16) Power-up or position reset captures home
      if (power_up) begin
        home_pos <= cmd_pos;
      end else if (preset) begin
        home_pos <= act_pos;
        cmd_pos <= act_pos;
        // (RULE20) Reset during return stops the motor
        returning <= 1'b0;
      end else if (returning) begin
        // (RULE17) Ramped return profile
        if (to_home == 32'sh0000_0000) begin
          returning <= 1'b0;
          cmd_pos <= act_pos;
        end else if (step_due) begin
          act_pos <= to_home[31] ? act_pos - 1 : act_pos + 1;
          step_out <= 1'b1;
          step_cw <= to_home[31] ^ ~dir_ccw;
          speed <= (speed > ret_speed + ret_accel) ?
            speed - ret_accel : ret_speed;
          rate_cnt <= speed;
        end else
          rate_cnt <= rate_cnt - 16'h0001;
      end else if (ret_go) begin
        // (RULE15) Request starts the return move
        returning <= 1'b1;
        speed <= ret_start;
        rate_cnt <= ret_start;
      end else if (jog_button) begin
        jogging <= 1'b1;
        // Ramp restarts at the start speed when jogging begins; a return run with the button held leaves its return speed
        if (!jogging) begin
          speed <= jog_start;
          rate_cnt <= jog_start;
        end else if (step_due) begin
          act_pos <= jog_dir ? act_pos - 1 : act_pos + 1;
          cmd_pos <= jog_dir ? cmd_pos - 1 : cmd_pos + 1;
          step_out <= 1'b1;
          step_cw <= jog_dir ^ ~dir_ccw;
          speed <= (speed > jog_speed + jog_accel) ?
            speed - jog_accel : jog_speed;
          rate_cnt <= speed;
        end else
          rate_cnt <= rate_cnt - 16'h0001;
      end else begin
        jogging <= 1'b0;
        // (RULE21) Forward up, reverse down; (RULE22) counter
        // (RULE18) Pulses are only counted outside a return move
        // (RULE6) Counted even when the shaft is held
        if (fwd_edge && !rev_edge)
          cmd_pos <= cmd_pos + 1;
        else if (rev_edge && !fwd_edge)
          cmd_pos <= cmd_pos - 1;
        // (RULE12) Load gone: drain backlog at fast rate
        fast_run <= pushing & (abs_dev > 32'h0000_0001);
        if (deviation != 32'sh0000_0000 && !load_held &&
            (step_due || !fast_run)) begin
          act_pos <= deviation[31] ? act_pos - 1 : act_pos + 1;
          step_out <= 1'b1;
          // (RULE1) (RULE2) Shaft sense from latched direction
          step_cw <= deviation[31] ^ ~dir_ccw;
          rate_cnt <= `FAST_PERIOD;
        end else if (!step_due)
          rate_cnt <= rate_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Torque limit, in-position, cutback and alarm outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      torque_limit <= `PUSH_CUR_FULL;
      torque_limit_flag <= 1'b0;
      in_position <= 1'b0;
      standstill_cutback <= 1'b0;
      deviation_alarm <= 1'b0;
    end else begin
      // (RULE8) Limit to the selected push current
      torque_limit <= pushing ? push_cur[cur_idx] : `PUSH_CUR_FULL;
      // (RULE9) Flag when torque reaches the limit
      torque_limit_flag <= pushing && torque_meas >= push_cur[cur_idx];
      // (RULE4) Offset-corrected deviation against band
      in_position <= !returning && !jogging &&
        abs_corr <= {16'h0000, inpos_band};
      // (RULE11) (RULE10) Full push current held while pushing
      standstill_cutback <= !pushing && !push_ok &&
        deviation == 32'sh0000_0000;
      // (RULE13) Alarm on excessive accumulated deviation
      if (abs_dev > {16'h0000, dev_limit})
        deviation_alarm <= 1'b1;
      else if (preset)
        deviation_alarm <= 1'b0;
    end
  end
endmodule

// file: tb/stepper_push_checks_asserts.sv
// Concurrent checks on the push and home-return block ports
`timescale 1ns/1ps
module stepper_push_checks (
  input wire clk, // Clock
  input wire rst, // Reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pready, // APB ready
  input wire load_held, // Stall input
  input wire push_mode_in, // Push request
  input wire resolution_select_in, // Resolution select
  input wire position_reset_in, // Position reset
  input wire [9:0] torque_meas, // Measured torque
  input wire [9:0] torque_limit, // Current limit
  input wire torque_limit_flag, // Limit reached
  input wire standstill_cutback, // Cutback allowed
  input wire step_out, // Step pulse
  input wire deviation_alarm, // Deviation alarm
  input wire bad_data_warning // Return blocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------
  // Sequences
  // ----------------
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  // Clears lag the two-stage synchroniser
  sequence s_preset_seen;
    $past(position_reset_in, 2) || $past(position_reset_in, 3) ||
      $past(position_reset_in, 4);
  endsequence
  // ----------------
  // Assertions
  // ----------------
  a_apb_answer: assert property (s_taken |=> pready)
    else $error("apb answer late");
  a_apb_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_tlim_idle: assert property (!push_mode_in [*5] |->
    torque_limit == 10'h3e8) else $error("limit not full outside push");
  a_flag_cause: assert property ($rose(torque_limit_flag) |->
    $past(torque_meas) >= torque_limit)
    else $error("torque flag without reaching limit");
  a_no_cutback: assert property (torque_limit < 10'h3e8 &&
    $past(torque_limit) < 10'h3e8 |-> !standstill_cutback)
    else $error("cutback during push");
  a_step_single: assert property (step_out |=> !step_out)
    else $error("step pulse too long");
  a_held_no_step: assert property (load_held [*3] |-> !step_out)
    else $error("step while stalled");
  a_warn_clear: assert property ($fell(bad_data_warning) |->
    s_preset_seen) else $error("warning cleared without reset");
  a_warn_cause: assert property ($rose(bad_data_warning) |->
    $past(resolution_select_in, 3)) else $error("warning without select");
  a_alarm_clear: assert property ($fell(deviation_alarm) |->
    s_preset_seen) else $error("alarm cleared without reset");
endmodule
bind stepper_push_home stepper_push_checks i_chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .load_held(load_held),
  .push_mode_in(push_mode_in), .resolution_select_in(resolution_select_in),
  .position_reset_in(position_reset_in), .torque_meas(torque_meas),
  .torque_limit(torque_limit), .torque_limit_flag(torque_limit_flag),
  .standstill_cutback(standstill_cutback), .step_out(step_out),
  .deviation_alarm(deviation_alarm), .bad_data_warning(bad_data_warning));

// file: tb/pulse_gen.sv
// Pulse generator controller model driving step and control pins
`timescale 1ns/1ps
module pulse_gen (
  input wire clk, // Clock
  output reg pulse_fwd, // Forward step line
  output reg pulse_rev, // Reverse step line
  output reg push_mode_in, // Push request
  output reg current_select_bit0, // Current select lsb
  output reg current_select_bit1, // Current select
  output reg current_select_bit2, // Current select msb
  output reg home_return_in, // Return request
  output reg position_reset_in, // Position reset
  output reg resolution_select_in // Resolution select
);
  initial begin
    {pulse_fwd, pulse_rev, push_mode_in} = 3'h0;
    {current_select_bit2, current_select_bit1, current_select_bit0} = 3'h0;
    {home_return_in, position_reset_in, resolution_select_in} = 3'h0;
  end
  // one line per direction, levels held four clocks
  task step(input f, input integer n);
    repeat (n) begin
      @(posedge clk);
      if (f) pulse_fwd <= 1'b1;
      else pulse_rev <= 1'b1;
      repeat (4) @(posedge clk);
      pulse_fwd <= 1'b0;
      pulse_rev <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // current first, then push; caller stops pulses first
  task push(input on, input [2:0] s);
    @(posedge clk);
    if (on) begin
      {current_select_bit2, current_select_bit1, current_select_bit0} <= s;
      repeat (4) @(posedge clk);
    end
    push_mode_in <= on;
    repeat (6) @(posedge clk);
  endtask
  // level held past the synchroniser; k 0 return, 1 reset
  task pin(input integer k);
    @(posedge clk);
    if (k == 0) home_return_in <= 1'b1;
    else position_reset_in <= 1'b1;
    repeat (6) @(posedge clk);
    home_return_in <= 1'b0;
    position_reset_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task res(input v);
    @(posedge clk);
    resolution_select_in <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the push and home-return block
`timescale 1ns/1ps
`include "stepper_push_map.vh"
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg power_up;
  reg load_held;
  reg [9:0] torque_meas;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire [9:0] torque_limit;
  wire pready, pslverr, step_out, step_cw, torque_limit_flag, in_position;
  wire standstill_cutback, deviation_alarm, bad_data_warning;
  wire pulse_fwd, pulse_rev, push_mode_in, sel0, sel1, sel2;
  wire home_return_in, position_reset_in, resolution_select_in;
  integer errors = 0;
  integer compares = 0;
  integer nst = 0;
  integer ncw = 0;
  integer i, base;
  reg [31:0] rdv;
  reg err;
  always #20 clk = ~clk;
  stepper_push_home i_dut (.clk(clk), .rst(rst), .power_up(power_up),
    .pulse_fwd(pulse_fwd), .pulse_rev(pulse_rev),
    .push_mode_in(push_mode_in), .current_select_bit0(sel0),
    .current_select_bit1(sel1), .current_select_bit2(sel2),
    .home_return_in(home_return_in), .position_reset_in(position_reset_in),
    .resolution_select_in(resolution_select_in), .load_held(load_held),
    .torque_meas(torque_meas), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_out(step_out),
    .step_cw(step_cw), .torque_limit(torque_limit),
    .torque_limit_flag(torque_limit_flag), .in_position(in_position),
    .standstill_cutback(standstill_cutback),
    .deviation_alarm(deviation_alarm), .bad_data_warning(bad_data_warning));
  pulse_gen i_gen (.clk(clk), .pulse_fwd(pulse_fwd), .pulse_rev(pulse_rev),
    .push_mode_in(push_mode_in), .current_select_bit0(sel0),
    .current_select_bit1(sel1), .current_select_bit2(sel2),
    .home_return_in(home_return_in), .position_reset_in(position_reset_in),
    .resolution_select_in(resolution_select_in));
  // Shaft steps seen at the drive stage
  always @(posedge clk) begin
    if (step_out === 1'b1) begin
      nst <= nst + 1;
      if (step_cw === 1'b1) ncw <= ncw + 1;
    end
  end
  // ----------------
  // Access tasks
  // ----------------
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task wait_steps(input integer n);
    i = 0;
    while (nst < n && i < 6000) begin
      @(posedge clk);
      i = i + 1;
    end
    repeat (4) @(posedge clk);
  endtask
  task print_verdict;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #2400000;
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    {power_up, load_held, torque_meas, psel, penable} <= 14'h0000;
    {pwrite, paddr, pwdata} <= 45'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    power_up <= 1'b1;
    @(posedge clk);
    power_up <= 1'b0;
    for (base = 0; base < 8; base = base + 1)
      rd(12'(`OFS_PUSH_CUR0 + 4 * base), 32'(300 + 100 * base));
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test defaults done");
    i_gen.step(1'b1, 5);
    i_gen.step(1'b0, 3);
    wait_steps(8);
    rd(`OFS_CMD_POS, 32'd2);
    chk(ncw, 5);
    apb(1'b1, `OFS_SYS_CFG, 32'h1);
    i_gen.step(1'b1, 1);
    wait_steps(9);
    chk(ncw, 6);
    @(posedge clk);
    power_up <= 1'b1;
    @(posedge clk);
    power_up <= 1'b0;
    rd(`OFS_HOME_POS, 32'd3);
    i_gen.step(1'b1, 1);
    i_gen.step(1'b0, 1);
    wait_steps(11);
    chk(ncw, 7);
    rd(`OFS_CMD_POS, 32'd3);
    $display("test direction done");
    apb(1'b1, `OFS_APP_CFG, 32'h1);
    apb(1'b1, `OFS_DEV_LIMIT, 32'h2);
    apb(1'b1, `OFS_INPOS_BAND, 32'h2);
    for (base = 0; base < 8; base = base + 1) begin
      i_gen.push(1'b1, 3'(base));
      i_gen.step(1'b1, 1);
      wait_steps(12 + base);
      chk({22'h0, torque_limit}, 32'(300 + 100 * base));
      i_gen.push(1'b0, 3'h0);
    end
    i_gen.push(1'b1, 3'h2);
    load_held <= 1'b1;
    torque_meas <= 10'h1f4;
    i_gen.step(1'b1, 4);
    repeat (8) @(posedge clk);
    rd(`OFS_CMD_POS, 32'd15);
    chk(nst, 19);
    chk({31'h0, torque_limit_flag}, 32'h1);
    chk({31'h0, standstill_cutback}, 32'h0);
    chk({31'h0, deviation_alarm}, 32'h1);
    chk({31'h0, in_position}, 32'h0);
    load_held <= 1'b0;
    torque_meas <= 10'h000;
    wait_steps(23);
    chk(nst, 23);
    i_gen.push(1'b0, 3'h0);
    chk({22'h0, torque_limit}, 32'h3e8);
    i_gen.pin(1);
    chk({31'h0, deviation_alarm}, 32'h0);
    rd(`OFS_HOME_POS, 32'd15);
    apb(1'b1, `OFS_DEV_LIMIT, 32'h2000);
    apb(1'b1, `OFS_INPOS_BAND, 32'ha);
    $display("test push done");
    i_gen.step(1'b1, 3);
    i_gen.pin(0);
    i_gen.step(1'b1, 1);
    wait_steps(29);
    repeat (400) @(posedge clk);
    chk(nst, 29);
    rd(`OFS_ACT_POS, 32'd15);
    i_gen.step(1'b1, 10);
    i_gen.pin(0);
    wait_steps(41);
    i_gen.pin(1);
    base = nst;
    rd(`OFS_HOME_POS, 32'(25 - (base - 39)));
    repeat (2000) @(posedge clk);
    chk(nst, base);
    $display("test return done");
    apb(1'b1, `OFS_APP_CFG, 32'h3);
    i_gen.res(1'b1);
    i_gen.step(1'b1, 2);
    wait_steps(base + 2);
    i_gen.pin(0);
    repeat (1000) @(posedge clk);
    chk({31'h0, bad_data_warning}, 32'h1);
    chk(nst, base + 2);
    i_gen.pin(1);
    i_gen.res(1'b0);
    chk({31'h0, bad_data_warning}, 32'h0);
    chk({31'h0, standstill_cutback}, 32'h1);
    chk({31'h0, in_position}, 32'h1);
    apb(1'b1, `OFS_INPOS_OFFSET, 32'hfff5);
    repeat (2) @(posedge clk);
    chk({31'h0, in_position}, 32'h0);
    $display("test warning done");
    base = nst;
    apb(1'b1, `OFS_JOG_CTRL, 32'h3);
    i_gen.step(1'b1, 1);
    repeat (400) @(posedge clk);
    apb(1'b1, `OFS_JOG_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    chk({31'h0, nst > base}, 32'h1);
    rd(`OFS_CMD_POS, 32'(25 - (nst - base)));
    $display("test jog done");
    print_verdict;
  end
endmodule
